/* src/down_timer_pwm_buzzer.sv */
// Ten-bit down timer with prescaler, buffered PWM and buzzer on one shared pin.
// Assumes all inputs are synchronous to sys_clk and the master never issues read and write together.
//
// Overview of operation
// - Counter is ten bits and steps down once per prescaled tick.
// - High reload bits go first; running timer takes new reload at underflow.
// - Low reload write with timer disabled loads the counter at once.
// - Reading the timer location returns the live count.
// - Counting happens only while enable bit is set; otherwise count holds.
// - Fast RC select wins; else source select picks pin or instruction clock.
// - Edge select set means falling pin edges count; clear means rising.
// - Prescaler active when its low enable is 0; ratio 1:2 to 1:256.
// - Prescaler count is readable through its own readback register.
// - One-shot mode counts down once, underflows once, then stops.
// - Continuous mode restarts from reload value or from all ones.
// - Underflow sets flag; request raised only with both enables set.
// - Flag stays set until software writes zero to it.
// - PWM enable makes the shared pin an output by itself.
// - Polarity bit set gives active-low PWM, clear gives active-high.
// - Duty zero never active; full duty active 1023 input clocks.
// - High duty bits go first; new duty takes effect at underflow.
// - Buzzer enable routes buzzer to the pin and makes it an output.
// - Buzzer source is prescaler or timer output, ratio 1:2 to 1:256.
// - With both enabled, the pin carries PWM and buzzer yields.
`timescale 1ns/1ns
module down_timer_pwm_buzzer
	import down_timer_pkg::*;
#(
	parameter int COUNT_W = 10,
	parameter int PRESCALE_W = 8
) (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Count sources
	input wire logic instr_tick,
	input wire logic external_count_pin,
	input wire logic internal_fast_oscillator,
	// Shared PWM / buzzer pin and interrupt request
	output logic pin_out,
	output logic pin_oe,
	output logic irq_req
);
	// The datapath is hard-wired around these widths
	if (COUNT_W != 10 || PRESCALE_W != 8) begin : g_width_check
		$error("down_timer_pwm_buzzer supports only COUNT_W=10 and PRESCALE_W=8");
	end

	tmr_state_s_t s_q;
	tmr_state_s_t s_d;
	reg_req_t req;
	pin_drive_t pin;
	logic src_tick;
	logic ps_tick;
	logic tick;
	logic underflow;
	logic buzz_src;
	logic pwm_active;
	logic pwm_level;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// True when the low (sel+1) bits of the count are all ones: end of a 2^(sel+1) period
	function automatic logic ratio_hit(input logic [7:0] cnt, input logic [2:0] sel);
		logic [8:0] wide;
		logic [7:0] mask;
		wide = (9'h002 << sel) - 9'h001;
		mask = wide[7:0];
		return (cnt & mask) == mask;
	endfunction : ratio_hit

	// Source selection and edge detection
	always_comb begin
		if (s_q.ctrl_one[CTRL1_FAST_RC]) begin
			src_tick = internal_fast_oscillator & ~s_q.hrc_q;
		end else if (s_q.ctrl_two[CTRL2_SRC_SEL]) begin
			if (s_q.ctrl_two[CTRL2_EDGE_SEL]) begin
				src_tick = ~external_count_pin & s_q.ext_q;
			end else begin
				src_tick = external_count_pin & ~s_q.ext_q;
			end
		end else begin
			src_tick = instr_tick;
		end
	end

	// Prescaler output; bypassed while its low-active enable is high
	assign ps_tick = src_tick & ratio_hit(s_q.prescale, s_q.ctrl_two[2:0]);
	assign tick = s_q.ctrl_two[CTRL2_PS_EN_N] ? src_tick : ps_tick;
	// Enable gates underflow so a stop in the same cycle never half-reloads
	assign underflow = (s_q.st == TMR_RUN) && s_q.ctrl_one[CTRL1_ENABLE] && tick
		&& (s_q.count == 10'h000);
	// Buzzer takes the timer underflow or the prescaler output (source itself when bypassed)
	assign buzz_src = s_q.buzz_ctrl[BUZZ_SRC] ? underflow : tick;
	// Active while the count sits below the duty: duty clocks per frame
	assign pwm_active = s_q.count < s_q.duty_act;
	assign pwm_level = pwm_active ^ s_q.ctrl_one[CTRL1_ACT_LOW];

	// Pin arbitration: PWM beats buzzer when both are enabled
	always_comb begin
		if (s_q.ctrl_one[CTRL1_PWM_OE]) begin
			pin.out = pwm_level;
		end else begin
			pin.out = s_q.buzz_wave;
		end
		pin.oe = s_q.ctrl_one[CTRL1_PWM_OE] | s_q.buzz_ctrl[BUZZ_EN];
	end

	// Next-state logic for the whole block
	always_comb begin
		s_d = s_q;
		s_d.ext_q = external_count_pin;
		s_d.hrc_q = internal_fast_oscillator;
		s_d.pin_out = pin.out;
		s_d.pin_oe = pin.oe;
		s_d.rdata = 8'h00;

		// Prescaler runs whenever the selected source ticks and its low-active enable is 0
		if (src_tick && !s_q.ctrl_two[CTRL2_PS_EN_N]) begin
			s_d.prescale = s_q.prescale + 8'h01;
		end

		// Timer sequencing
		case (s_q.st)
			TMR_IDLE: begin
				if (s_q.ctrl_one[CTRL1_ENABLE]) begin
					s_d.st = TMR_RUN;
				end
			end
			TMR_RUN: begin
				if (!s_q.ctrl_one[CTRL1_ENABLE]) begin
					s_d.st = TMR_IDLE;
				end else if (underflow) begin
					s_d.duty_act = s_q.duty_buf;
					if (s_q.ctrl_one[CTRL1_ONE_SHOT]) begin
						s_d.count = s_q.reload_buf;
						s_d.st = TMR_DONE;
					end else if (s_q.ctrl_one[CTRL1_RELOAD]) begin
						s_d.count = s_q.reload_buf;
					end else begin
						s_d.count = COUNT_ALL_ONES;
					end
				end else if (tick) begin
					s_d.count = s_q.count - 10'h001;
				end
			end
			TMR_DONE: begin
				if (!s_q.ctrl_one[CTRL1_ENABLE]) begin
					s_d.st = TMR_IDLE;
				end
			end
			default: begin
				s_d.st = TMR_IDLE;
			end
		endcase

		// Buzzer divider: one toggle per completed period
		if (buzz_src) begin
			if (ratio_hit(s_q.buzz_cnt, s_q.buzz_ctrl[2:0])) begin
				s_d.buzz_cnt = 8'h00;
				s_d.buzz_wave = ~s_q.buzz_wave;
			end else begin
				s_d.buzz_cnt = s_q.buzz_cnt + 8'h01;
			end
		end

		// Register writes
		if (req.wr) begin
			case (req.addr)
				ADDR_CTRL_ONE: begin
					s_d.ctrl_one = req.wdata & 8'hcf;
					// Rewriting the control register re-arms a finished one-shot
					if (s_q.st == TMR_DONE) begin
						s_d.st = TMR_IDLE;
					end
				end
				ADDR_CTRL_TWO: begin
					s_d.ctrl_two = req.wdata & 8'h3f;
					s_d.prescale = 8'h00;
				end
				ADDR_HIGH_BITS: begin
					s_d.reload_hi = req.wdata[HIGH_RELOAD_LSB +: 2];
					s_d.duty_hi = req.wdata[HIGH_DUTY_LSB +: 2];
				end
				ADDR_RELOAD_LOW: begin
					s_d.reload_buf = {s_q.reload_hi, req.wdata};
					if (!s_q.ctrl_one[CTRL1_ENABLE]) begin
						s_d.count = {s_q.reload_hi, req.wdata};
					end
				end
				ADDR_DUTY_LOW: begin
					s_d.duty_buf = {s_q.duty_hi, req.wdata};
				end
				ADDR_BUZZ_CTRL: begin
					s_d.buzz_ctrl = req.wdata & 8'h8f;
					s_d.buzz_cnt = 8'h00; // New ratio starts a clean period
				end
				ADDR_IRQ_FLAG: begin
					// Only a written zero clears; set below still wins
					if (!req.wdata[FLAG_UNDERFLOW]) begin
						s_d.flag = 1'b0;
					end
				end
				ADDR_IRQ_ENABLE: begin
					s_d.irq_en = req.wdata[IE_UNDERFLOW];
					s_d.global_irq_enable = req.wdata[IE_GLOBAL];
				end
				default: begin
				end
			endcase
		end

		// Underflow sets the flag after any clear in the same cycle
		if (underflow) begin
			s_d.flag = 1'b1;
		end

		// Register reads; unmapped indices read zero
		if (req.rd) begin
			case (req.addr)
				ADDR_CTRL_ONE: s_d.rdata = s_q.ctrl_one;
				ADDR_CTRL_TWO: s_d.rdata = s_q.ctrl_two;
				ADDR_HIGH_BITS: s_d.rdata = {2'b00, s_q.count[9:8], 2'b00, s_q.duty_hi};
				ADDR_RELOAD_LOW: s_d.rdata = s_q.count[7:0];
				ADDR_DUTY_LOW: s_d.rdata = s_q.duty_buf[7:0];
				ADDR_PRESCALE_RB: s_d.rdata = s_q.prescale;
				ADDR_BUZZ_CTRL: s_d.rdata = s_q.buzz_ctrl;
				ADDR_IRQ_FLAG: s_d.rdata = {4'h0, s_q.flag, 3'b000};
				ADDR_IRQ_ENABLE: s_d.rdata = {s_q.global_irq_enable, 3'b000, s_q.irq_en, 3'b000};
				default: s_d.rdata = 8'h00;
			endcase
		end
	end

	// State register; clock enable freezes everything
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_q <= '{st: TMR_IDLE, ctrl_one: CTRL_ONE_RST, ctrl_two: CTRL_TWO_RST,
				reload_hi: 2'b00, duty_hi: 2'b00, reload_buf: COUNT_RST,
				duty_buf: DUTY_RST, duty_act: DUTY_RST, count: COUNT_RST,
				prescale: 8'h00, buzz_ctrl: 8'h00, buzz_cnt: 8'h00, buzz_wave: 1'b0,
				flag: 1'b0, irq_en: 1'b0, global_irq_enable: 1'b0, ext_q: 1'b0, hrc_q: 1'b0,
				rdata: 8'h00, pin_out: 1'b0, pin_oe: 1'b0};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign reg_rdata = s_q.rdata;
	assign pin_out = s_q.pin_out;
	assign pin_oe = s_q.pin_oe;
	// Request is gated by both enables; handshake-class, so combinational from flops
	assign irq_req = s_q.flag & s_q.irq_en & s_q.global_irq_enable;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	flag_set_a: assert property (ce && underflow |=> s_q.flag)
		else $error("underflow did not set flag");
	flag_hold_a: assert property (ce && s_q.flag && !(req.wr && req.addr == ADDR_IRQ_FLAG)
		|=> s_q.flag)
		else $error("flag cleared without a zero write");
	count_hold_a: assert property (ce && !s_q.ctrl_one[CTRL1_ENABLE]
		&& !(req.wr && req.addr == ADDR_RELOAD_LOW) |=> $stable(s_q.count))
		else $error("count moved while disabled");
	count_step_a: assert property (ce && s_q.st == TMR_RUN && s_q.ctrl_one[CTRL1_ENABLE]
		&& tick && s_q.count != 10'h000 && !req.wr |=> s_q.count == $past(s_q.count) - 10'h001)
		else $error("count did not step down by one");
	direct_load_a: assert property (ce && req.wr && req.addr == ADDR_RELOAD_LOW
		&& !s_q.ctrl_one[CTRL1_ENABLE] |=> s_q.count == {$past(s_q.reload_hi), $past(req.wdata)})
		else $error("disabled reload write did not load counter");
	free_run_a: assert property (ce && underflow && !s_q.ctrl_one[CTRL1_ONE_SHOT]
		&& !s_q.ctrl_one[CTRL1_RELOAD] && !req.wr |=> s_q.count == COUNT_ALL_ONES)
		else $error("free run did not restart from all ones");
	one_shot_a: assert property (ce && underflow && s_q.ctrl_one[CTRL1_ONE_SHOT] && !req.wr
		|=> s_q.st == TMR_DONE ##1 !underflow)
		else $error("one-shot did not stop");
	duty_take_a: assert property (ce && underflow |=> s_q.duty_act == $past(s_q.duty_buf))
		else $error("duty not transferred at underflow");
	read_count_a: assert property (ce && req.rd && req.addr == ADDR_RELOAD_LOW
		|=> reg_rdata == $past(s_q.count[7:0]))
		else $error("timer read did not return count");
	pwm_prio_a: assert property (ce && s_q.ctrl_one[CTRL1_PWM_OE] && s_q.buzz_ctrl[BUZZ_EN]
		|=> pin_oe && pin_out == $past(pwm_level))
		else $error("buzzer took pin from PWM");
endmodule : down_timer_pwm_buzzer

/* src/down_timer_pkg.sv */
// Constants, register map and state types for the down-counting timer with PWM and buzzer.
// Assumes an 8-bit register port and a single system clock.
package down_timer_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
	localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
	localparam logic [3:0] ADDR_HIGH_BITS = 4'h2;
	localparam logic [3:0] ADDR_RELOAD_LOW = 4'h3;
	localparam logic [3:0] ADDR_DUTY_LOW = 4'h4;
	localparam logic [3:0] ADDR_PRESCALE_RB = 4'h5;
	localparam logic [3:0] ADDR_BUZZ_CTRL = 4'h6;
	localparam logic [3:0] ADDR_IRQ_FLAG = 4'h7;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h8;
	// Field positions
	localparam int CTRL1_ENABLE = 0;
	localparam int CTRL1_RELOAD = 1;
	localparam int CTRL1_ONE_SHOT = 2;
	localparam int CTRL1_FAST_RC = 3;
	localparam int CTRL1_ACT_LOW = 6;
	localparam int CTRL1_PWM_OE = 7;
	localparam int CTRL2_SRC_SEL = 5;
	localparam int CTRL2_EDGE_SEL = 4;
	localparam int CTRL2_PS_EN_N = 3;
	localparam int HIGH_RELOAD_LSB = 4;
	localparam int HIGH_DUTY_LSB = 0;
	localparam int FLAG_UNDERFLOW = 3;
	localparam int IE_UNDERFLOW = 3;
	localparam int IE_GLOBAL = 7;
	localparam int BUZZ_EN = 7;
	localparam int BUZZ_SRC = 3;
	// Values after reset
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST = 8'h08;
	localparam logic [9:0] COUNT_RST = 10'h3ff;
	localparam logic [9:0] COUNT_ALL_ONES = 10'h3ff;
	localparam logic [9:0] DUTY_RST = 10'h000;

	typedef enum logic [1:0] {
		TMR_IDLE = 2'b00,
		TMR_RUN = 2'b01,
		TMR_DONE = 2'b10
	} tmr_state_t;

	// Register-port request bundle
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// Shared pin bundle
	typedef struct packed {
		logic out;
		logic oe;
	} pin_drive_t;

	// Whole block state
	typedef struct packed {
		tmr_state_t st;
		logic [7:0] ctrl_one;
		logic [7:0] ctrl_two;
		logic [1:0] reload_hi;
		logic [1:0] duty_hi;
		logic [9:0] reload_buf;
		logic [9:0] duty_buf;
		logic [9:0] duty_act;
		logic [9:0] count;
		logic [7:0] prescale;
		logic [7:0] buzz_ctrl;
		logic [7:0] buzz_cnt;
		logic buzz_wave;
		logic flag;
		logic irq_en;
		logic global_irq_enable;
		logic ext_q;
		logic hrc_q;
		logic [7:0] rdata;
		logic pin_out;
		logic pin_oe;
	} tmr_state_s_t;
endpackage : down_timer_pkg

/* tb/test_down_timer_pwm_buzzer.sv */
// Self-checking bench for the down timer with PWM and buzzer on the shared pin.
// Assumes the assertions live in the design; bench drives every port itself.
`timescale 1ns/1ns
`define CHK(a, e) begin \
	n_tests++; \
	if ((a) !== (e)) begin \
		mismatches++; \
		$display("ERROR at %0t ns: got %h, expected %h", $time, (a), (e)); \
	end \
end
module test_down_timer_pwm_buzzer;
	import down_timer_pkg::*;
	logic sys_clk, srst, ce, reg_wr, reg_rd, instr_tick, ext_pin, fast_osc;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic pin_out, pin_oe, irq_req, rd_seen, b;
	logic [7:0] exp_q[$];
	logic [9:0] rl;
	logic [7:0] e_v;
	int mismatches = 0;
	int n_tests = 0;
	int i, k;
	logic [7:0] c1[3] = '{8'h01, 8'h01, 8'h09};
	logic [7:0] c2[3] = '{8'h28, 8'h38, 8'h28};
	logic [9:0] dec[3] = '{10'd4, 10'd3, 10'd5};

	down_timer_pwm_buzzer dut (.sys_clk(sys_clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.instr_tick(instr_tick), .external_count_pin(ext_pin),
		.internal_fast_oscillator(fast_osc), .pin_out(pin_out), .pin_oe(pin_oe),
		.irq_req(irq_req));

	// Clock, 50 ns period
	initial begin
		sys_clk = 0;
		forever #25 sys_clk = ~sys_clk;
	end

	// Read data stand only in the cycle after the strobe, so sample mid-cycle
	initial rd_seen = 0;
	always @(negedge sys_clk) begin
		if (rd_seen) begin
			e_v = exp_q.pop_front();
			`CHK(reg_rdata, e_v)
		end
		rd_seen = reg_rd;
	end

	// Hang guard, well above the expected run length
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		stop_test();
	end

	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask : rd

	// One-cycle count pulses, then let the pipeline settle
	task automatic tk(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			instr_tick <= 1'b1;
			@(posedge sys_clk);
			instr_tick <= 1'b0;
		end
		repeat (3) @(posedge sys_clk);
	endtask : tk

	// Stop the timer, then high bits before the low byte
	task automatic load(input logic [9:0] v);
		wr(ADDR_CTRL_ONE, 8'h00);
		wr(ADDR_HIGH_BITS, {2'b00, v[9:8], 4'h0});
		wr(ADDR_RELOAD_LOW, v[7:0]);
	endtask : load

	task automatic chkc(input logic [9:0] v);
		rd(ADDR_RELOAD_LOW, v[7:0]);
		rd(ADDR_HIGH_BITS, {2'b00, v[9:8], 4'h0});
	endtask : chkc

	initial begin
		{srst, reg_wr, reg_rd, instr_tick, ext_pin, fast_osc} = 6'b100000;
		ce = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		rl = 10'($urandom(32'h1db0));
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		rd(ADDR_CTRL_TWO, CTRL_TWO_RST);
		chkc(COUNT_RST);
		rd(4'hf, 8'h00);
		$display("reset values done");
		rl = 10'($urandom());
		load(rl);
		chkc(rl);
		load(10'h120);
		tk(3);
		chkc(10'h120);
		wr(ADDR_CTRL_ONE, 8'h01);
		tk(5);
		chkc(10'h11b);
		wr(ADDR_CTRL_TWO, 8'h07);
		tk(3);
		rd(ADDR_PRESCALE_RB, 8'h03);
		load(10'h100);
		wr(ADDR_CTRL_TWO, 8'h01);
		wr(ADDR_CTRL_ONE, 8'h01);
		tk(8);
		chkc(10'h0fe);
		$display("count and prescaler done");
		// Pin edges versus fast oscillator priority
		wr(ADDR_CTRL_TWO, 8'h08);
		for (k = 0; k < 3; k++) begin
			load(10'h200);
			wr(ADDR_CTRL_TWO, c2[k]);
			wr(ADDR_CTRL_ONE, c1[k]);
			for (i = 0; i < 10; i++) begin
				repeat (2) @(posedge sys_clk);
				fast_osc <= ~fast_osc;
				if (i < 7)
					ext_pin <= ~ext_pin;
			end
			tk(0);
			chkc(10'h200 - dec[k]);
			wr(ADDR_CTRL_ONE, 8'h00);
			ext_pin <= 1'b0;
		end
		wr(ADDR_CTRL_TWO, 8'h08);
		$display("clock sources done");
		// One-shot: single underflow, flag sticks until written zero
		load(10'h003);
		wr(ADDR_IRQ_ENABLE, 8'h08);
		wr(ADDR_CTRL_ONE, 8'h05);
		tk(12);
		rd(ADDR_IRQ_FLAG, 8'h08);
		chkc(10'h003);
		`CHK(irq_req, 1'b0)
		wr(ADDR_IRQ_ENABLE, 8'h88);
		wr(ADDR_IRQ_FLAG, 8'h08);
		tk(0);
		`CHK(irq_req, 1'b1)
		wr(ADDR_IRQ_FLAG, 8'h00);
		tk(0);
		`CHK(irq_req, 1'b0)
		rd(ADDR_IRQ_FLAG, 8'h00);
		// Continuous modes, new reload taken only at underflow
		load(10'h002);
		wr(ADDR_CTRL_ONE, 8'h01);
		tk(4);
		chkc(10'h3fe);
		load(10'h002);
		wr(ADDR_CTRL_ONE, 8'h03);
		wr(ADDR_HIGH_BITS, 8'h00);
		wr(ADDR_RELOAD_LOW, 8'h05);
		tk(2);
		chkc(10'h000);
		tk(2);
		chkc(10'h004);
		$display("modes and flag done");
		// PWM: buffered duty, enable, polarity, pin priority
		load(10'h003);
		wr(ADDR_DUTY_LOW, 8'h03);
		wr(ADDR_CTRL_ONE, 8'h80);
		tk(0);
		`CHK(pin_oe, 1'b1)
		`CHK(pin_out, 1'b0)
		wr(ADDR_CTRL_ONE, 8'hc0);
		tk(0);
		`CHK(pin_out, 1'b1)
		wr(ADDR_CTRL_ONE, 8'hc3);
		tk(5);
		`CHK(pin_out, 1'b0)
		wr(ADDR_BUZZ_CTRL, 8'h80);
		for (i = 0; i < 2; i++) begin
			tk(1);
			`CHK(pin_out, 1'b0)
		end
		// Buzzer alone from the undivided source, 1:2
		wr(ADDR_CTRL_ONE, 8'h03);
		tk(0);
		`CHK(pin_oe, 1'b1)
		b = pin_out;
		tk(2);
		`CHK(pin_out, ~b)
		tk(2);
		`CHK(pin_out, b)
		$display("pwm and buzzer done");
		repeat (4) @(posedge sys_clk);
		stop_test();
	end
endmodule : test_down_timer_pwm_buzzer
